// [design/pixdemux_pkg.sv]
package pixdemux_pkg;

  // One pixel across the three colour channels, bit 7 of each byte is the MSB.
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } chan_data_t;

  // Everything that leaves the block on one output edge, delayed as one unit.
  typedef struct packed {
    chan_data_t port_a;
    chan_data_t port_b;
    logic       strobe;
    logic       line_sync;
  } out_word_t;

  // Width of the sample phase setting and depth of the phase delay line.
  localparam int PHASE_W     = 3;
  localparam int DELAY_DEPTH = 8;

  // Number of pin inputs passed through the two-flop synchroniser.
  localparam int SYNC_W = 32;

  // Bit positions of each pin inside the synchroniser vector.
  localparam int SYNC_PIX_CLK_POS  = 0;
  localparam int SYNC_LINE_POS     = 1;
  localparam int SYNC_PWR_N_POS    = 2;
  localparam int SYNC_GREEN_POS    = 3;
  localparam int SYNC_ADDR_POS     = 4;
  localparam int SYNC_SCL_POS      = 6;
  localparam int SYNC_SDA_POS      = 7;
  localparam int SYNC_SAMPLE_POS   = 8;

  // Serial bus address: fixed upper bits, bits 2:1 from the straps.
  localparam logic [7:0] BUS_ADDR_BASE = 8'h98;

  // Values held after reset.
  localparam logic [SYNC_W-1:0] SYNC_RESET = 32'h0000_0004;
  localparam chan_data_t        DATA_RESET = 24'h00_0000;
  localparam out_word_t         WORD_RESET = 50'h0;

endpackage : pixdemux_pkg

// [design/strobe_gen.sv]
`timescale 1ns/10ps

// Builds the output data strobe from the sampled pixel clock.
module strobe_gen
  import pixdemux_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Pixel clock level and its rising-edge event.
  input  wire logic pix_level_in,
  input  wire logic pix_rise_in,
  // Mode and run control.
  input  wire logic dual_in,
  input  wire logic run_in,
  // Strobe towards the delay line.
  output logic      strobe_out
);

  logic half_rate_reg;  // Toggles once per pixel for dual-port operation.

  // In dual-port mode the strobe toggles each pixel, giving half the pixel
  // rate; the toggle restarts low when stopped so the phase is repeatable.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !run_in)
    begin
      half_rate_reg <= 1'b0;
    end
    else if (pix_rise_in)
    begin
      half_rate_reg <= ~half_rate_reg;
    end
  end

  // Single-port mode follows the pixel clock itself, so the strobe runs at
  // the pixel sampling frequency; a stopped generator holds the strobe low.
  always_comb
  begin
    if (!run_in)
    begin
      strobe_out = 1'b0;
    end
    else if (dual_in)
    begin
      strobe_out = half_rate_reg;
    end
    else
    begin
      strobe_out = pix_level_in;
    end
  end

endmodule : strobe_gen

// [design/pixel_output_dual_port_select.sv]
`timescale 1ns/10ps

module pixel_output_dual_port_select
  import pixdemux_pkg::*;
(
  // System clock and synchronous active-low reset.
  input  wire logic               SYS_CLK_IN,
  input  wire logic               RESETN_IN,
  // Pixel sampling clock, samples and line sync from the front end.
  input  wire logic               PIX_CLK_IN,
  input  wire chan_data_t         SAMPLE_IN,
  input  wire logic               LINE_SYNC_IN,
  input  wire logic               LINE_SYNC_POL_IN,
  // Output configuration held by the control registers.
  input  wire logic               DUAL_PORT_SELECT_IN,
  input  wire logic               PARALLEL_OUTPUT_SELECT_IN,
  input  wire logic [PHASE_W-1:0] SAMPLE_PHASE_IN,
  // Pins: power-down, green sync slice, address straps, serial port.
  input  wire logic               LOW_POWER_REQUEST_N_IN,
  input  wire logic               GREEN_SYNC_SLICE_IN,
  input  wire logic [1:0]         BUS_ADDRESS_LOW_PINS_IN,
  input  wire logic               SERIAL_CLK_IN,
  input  wire logic               SERIAL_DATA_IN,
  output logic                    SERIAL_DATA_OUT,
  output logic                    SERIAL_DATA_OE_OUT,
  // Serial port view handed to the control register logic.
  output logic                    SERIAL_CLK_SYNC_OUT,
  output logic                    SERIAL_DATA_SYNC_OUT,
  output logic [7:0]              BUS_ADDRESS_OUT,
  // Pixel data ports with their output enables.
  output chan_data_t              PORT_A_OUT,
  output logic                    PORT_A_OE_OUT,
  output chan_data_t              PORT_B_OUT,
  output logic                    PORT_B_OE_OUT,
  // Data strobe pair and line sync output with their enable.
  output logic                    OUTPUT_DATA_STROBE_OUT,
  output logic                    OUTPUT_DATA_STROBE_N_OUT,
  output logic                    LINE_SYNC_OUT,
  output logic                    TIMING_OE_OUT,
  // Green sync slicer output, never floated.
  output logic                    GREEN_SYNC_SLICE_OUT
);

  logic [SYNC_W-1:0] async_vec;       // All pins that cross into this domain.
  logic [SYNC_W-1:0] meta_reg;        // First synchroniser stage, read by stage two only.
  logic [SYNC_W-1:0] sync_reg;        // Second synchroniser stage, safe to use.
  logic              pix_prev_reg;    // Pixel clock level one cycle back.
  logic              pix_rise;        // One-cycle event on a pixel clock rising edge.
  logic              run;             // Clock generator running (not powered down).
  logic              sync_level;      // Line sync, normalised to active high.
  logic              sync_prev_reg;   // Normalised line sync at the previous pixel.
  logic              sel_b_reg;       // Next pixel goes to port B when set.
  chan_data_t        hold_a_reg;      // Port A pixel held for parallel output.
  chan_data_t        port_a_reg;      // Port A data before the phase delay.
  chan_data_t        port_b_reg;      // Port B data before the phase delay.
  logic              line_out_reg;    // Line sync before the phase delay.
  logic              strobe;          // Strobe before the phase delay.
  out_word_t         dly_reg [DELAY_DEPTH];  // Phase delay line.
  out_word_t         tap_reg;         // Output word chosen by the phase setting.
  logic [1:0]        addr_low_reg;    // Synchronised strap levels.

  // Gather every pin that arrives from outside this clock domain.
  assign async_vec = {SAMPLE_IN, SERIAL_DATA_IN, SERIAL_CLK_IN, BUS_ADDRESS_LOW_PINS_IN,
                      GREEN_SYNC_SLICE_IN, LOW_POWER_REQUEST_N_IN, LINE_SYNC_IN, PIX_CLK_IN};

  // Two flip-flops per pin; the samples ride through the same stages as the
  // pixel clock, so they stay lined up with the edge that is detected below.
  generate
    for (genvar i = 0; i < SYNC_W; i++)
    begin : g_sync
      always_ff @(posedge SYS_CLK_IN)
      begin
        if (!RESETN_IN)
        begin
          meta_reg[i] <= SYNC_RESET[i];
          sync_reg[i] <= SYNC_RESET[i];
        end
        else
        begin
          meta_reg[i] <= async_vec[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  // Power-down stops the pixel event stream, which is what stopping the
  // clock generator means here; mode inputs are untouched so settings stay.
  assign run = sync_reg[SYNC_PWR_N_POS];

  // Pixel clock edge detector on the synchronised level.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      pix_prev_reg <= 1'b0;
    end
    else
    begin
      pix_prev_reg <= sync_reg[SYNC_PIX_CLK_POS];
    end
  end

  assign pix_rise = run && sync_reg[SYNC_PIX_CLK_POS] && !pix_prev_reg;

  // Whatever the input polarity, the sync carried forward is active high.
  assign sync_level = sync_reg[SYNC_LINE_POS] ^ ~LINE_SYNC_POL_IN;

  // Line sync output, updated on pixel edges so it keeps step with the data.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      sync_prev_reg <= 1'b0;
      line_out_reg  <= 1'b0;
    end
    else if (pix_rise)
    begin
      sync_prev_reg <= sync_level;
      line_out_reg  <= sync_level;
    end
  end

  // Port select: a new line sync forces the pixel after it to port B, so a mode
  // change between lines never leaves the pair misaligned.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      sel_b_reg <= 1'b0;
    end
    else if (pix_rise)
    begin
      if (sync_level && !sync_prev_reg)
      begin
        sel_b_reg <= 1'b1;
      end
      else
      begin
        sel_b_reg <= DUAL_PORT_SELECT_IN && !sel_b_reg;
      end
    end
  end

  // Data steering. The pixel on the sync edge itself is the first one of the
  // line and therefore lands on port A regardless of the old select.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      hold_a_reg <= DATA_RESET;
      port_a_reg <= DATA_RESET;
      port_b_reg <= DATA_RESET;
    end
    else if (pix_rise)
    begin
      if (!DUAL_PORT_SELECT_IN)
      begin
        port_a_reg <= sync_reg[SYNC_SAMPLE_POS +: 24];
      end
      else if (sel_b_reg && !(sync_level && !sync_prev_reg))
      begin
        // Second pixel of a pair.
        port_b_reg <= sync_reg[SYNC_SAMPLE_POS +: 24];
        if (PARALLEL_OUTPUT_SELECT_IN)
        begin
          port_a_reg <= hold_a_reg;
        end
      end
      else if (PARALLEL_OUTPUT_SELECT_IN)
      begin
        // First pixel of a parallel pair waits for its partner.
        hold_a_reg <= sync_reg[SYNC_SAMPLE_POS +: 24];
      end
      else
      begin
        port_a_reg <= sync_reg[SYNC_SAMPLE_POS +: 24];
      end
    end
  end

  // Strobe source; a stopped generator parks the strobe low.
  strobe_gen u_strobe_gen (
    .clk_in       (SYS_CLK_IN),
    .rst_n_in     (RESETN_IN),
    .pix_level_in (sync_reg[SYNC_PIX_CLK_POS] && pix_prev_reg),
    .pix_rise_in  (pix_rise),
    .dual_in      (DUAL_PORT_SELECT_IN),
    .run_in       (run),
    .strobe_out   (strobe)
  );

  // Data, strobe and line sync enter one shared delay line, so the phase
  // setting moves all of them by the same amount and never apart.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      for (int k = 0; k < DELAY_DEPTH; k++)
      begin
        dly_reg[k] <= WORD_RESET;
      end
      tap_reg <= WORD_RESET;
    end
    else
    begin
      dly_reg[0] <= '{port_a: port_a_reg, port_b: port_b_reg,
                      strobe: strobe, line_sync: line_out_reg};
      for (int k = 1; k < DELAY_DEPTH; k++)
      begin
        dly_reg[k] <= dly_reg[k-1];
      end
      tap_reg <= dly_reg[SAMPLE_PHASE_IN];
    end
  end

  // Registered outputs; the complement is built from the same flop so the
  // pair never skews, and capture logic may use either edge.
  assign PORT_A_OUT               = tap_reg.port_a;
  assign PORT_B_OUT               = tap_reg.port_b;
  assign OUTPUT_DATA_STROBE_OUT   = tap_reg.strobe;
  assign OUTPUT_DATA_STROBE_N_OUT = ~tap_reg.strobe;
  assign LINE_SYNC_OUT            = tap_reg.line_sync;

  // Output enables: port B only drives in dual-port mode; power-down floats
  // every data and timing output.
  assign PORT_A_OE_OUT = run;
  assign PORT_B_OE_OUT = run && DUAL_PORT_SELECT_IN;
  assign TIMING_OE_OUT = run;

  // The slicer output is only synchronised and is not gated by power-down.
  assign GREEN_SYNC_SLICE_OUT = sync_reg[SYNC_GREEN_POS];

  // Straps follow their synchronised levels on every cycle. The synchroniser
  // itself is cleared by reset, so sampling only once just after release
  // would see its reset value instead of the pins.
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      addr_low_reg <= 2'h0;
    end
    else
    begin
      addr_low_reg <= sync_reg[SYNC_ADDR_POS +: 2];
    end
  end

  // Address with read/write bit zero; straps fill bits 2:1, giving 98h-9Eh.
  assign BUS_ADDRESS_OUT = BUS_ADDR_BASE | {5'h00, addr_low_reg, 1'b0};

  // The serial clock is only ever an input; the data line is released here
  // and is driven low only by the protocol logic, which lives elsewhere.
  assign SERIAL_CLK_SYNC_OUT  = sync_reg[SYNC_SCL_POS];
  assign SERIAL_DATA_SYNC_OUT = sync_reg[SYNC_SDA_POS];
  assign SERIAL_DATA_OUT      = 1'b0;
  assign SERIAL_DATA_OE_OUT   = 1'b0;

endmodule : pixel_output_dual_port_select

// [verif/pod_monitor.sv]
`timescale 1ns/10ps
// Watches the port timing rules of the dual_port_select from its top-level ports.
module pod_monitor
  import pixdemux_pkg::*;
(
  // Clock, reset and pins.
  input wire logic       SYS_CLK_IN,
  input wire logic       RESETN_IN,
  input wire logic       DUAL_PORT_SELECT_IN,
  input wire logic       PARALLEL_OUTPUT_SELECT_IN,
  input wire logic       LOW_POWER_REQUEST_N_IN,
  input wire logic       GREEN_SYNC_SLICE_IN,
  input wire logic [1:0] BUS_ADDRESS_LOW_PINS_IN,
  // Outputs under watch.
  input wire logic [7:0] BUS_ADDRESS_OUT,
  input wire chan_data_t PORT_A_OUT,
  input wire logic       PORT_A_OE_OUT,
  input wire logic       PORT_B_OE_OUT,
  input wire logic       OUTPUT_DATA_STROBE_OUT,
  input wire logic       OUTPUT_DATA_STROBE_N_OUT,
  input wire logic       GREEN_SYNC_SLICE_OUT
);
  // One clock domain, so one default clock and reset serve all.
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_strobe_pair_inverse: assert property (
    OUTPUT_DATA_STROBE_N_OUT == !OUTPUT_DATA_STROBE_OUT)
    else $error("strobe pair not complementary");
  a_port_b_single: assert property (
    PORT_B_OE_OUT |-> DUAL_PORT_SELECT_IN)
    else $error("port B driven in single mode");
  // The power pin crosses two sync flops, so four low samples must float.
  a_powerdown_float: assert property (
    (!LOW_POWER_REQUEST_N_IN) [*4] |-> !PORT_A_OE_OUT)
    else $error("outputs driven while powered down");
  a_powered_drive: assert property (
    LOW_POWER_REQUEST_N_IN [*4] |-> PORT_A_OE_OUT)
    else $error("outputs floated while running");
  a_frozen_data: assert property (
    (!LOW_POWER_REQUEST_N_IN) [*4] |-> $stable(PORT_A_OUT))
    else $error("data moved while powered down");
  a_green_pass: assert property ($past(RESETN_IN) && $past(RESETN_IN, 2)
    |-> GREEN_SYNC_SLICE_OUT == $past(GREEN_SYNC_SLICE_IN, 2))
    else $error("green slice not passed through");
  a_address_straps: assert property ($stable(BUS_ADDRESS_LOW_PINS_IN) [*4]
    |-> BUS_ADDRESS_OUT == (BUS_ADDR_BASE | {5'h00, BUS_ADDRESS_LOW_PINS_IN, 1'h0}))
    else $error("bus address does not follow straps");
  a_parallel_pairs: assert property (
    DUAL_PORT_SELECT_IN && PARALLEL_OUTPUT_SELECT_IN
    && $changed(PORT_A_OUT) |-> $changed(OUTPUT_DATA_STROBE_OUT))
    else $error("parallel data moved without strobe edge");
  // Main scenarios reached.
  c_dual_strobe: cover property (DUAL_PORT_SELECT_IN && $rose(OUTPUT_DATA_STROBE_OUT));
  c_powered_down: cover property (!PORT_A_OE_OUT);
  c_top_address: cover property (BUS_ADDRESS_OUT == 8'h9E);
endmodule : pod_monitor

bind pixel_output_dual_port_select pod_monitor u_pod_monitor (
  .SYS_CLK_IN                (SYS_CLK_IN),
  .RESETN_IN                 (RESETN_IN),
  .DUAL_PORT_SELECT_IN       (DUAL_PORT_SELECT_IN),
  .PARALLEL_OUTPUT_SELECT_IN (PARALLEL_OUTPUT_SELECT_IN),
  .LOW_POWER_REQUEST_N_IN    (LOW_POWER_REQUEST_N_IN),
  .GREEN_SYNC_SLICE_IN       (GREEN_SYNC_SLICE_IN),
  .BUS_ADDRESS_LOW_PINS_IN   (BUS_ADDRESS_LOW_PINS_IN),
  .BUS_ADDRESS_OUT           (BUS_ADDRESS_OUT),
  .PORT_A_OUT                (PORT_A_OUT),
  .PORT_A_OE_OUT             (PORT_A_OE_OUT),
  .PORT_B_OE_OUT             (PORT_B_OE_OUT),
  .OUTPUT_DATA_STROBE_OUT    (OUTPUT_DATA_STROBE_OUT),
  .OUTPUT_DATA_STROBE_N_OUT  (OUTPUT_DATA_STROBE_N_OUT),
  .GREEN_SYNC_SLICE_OUT      (GREEN_SYNC_SLICE_OUT)
);

// [verif/capture_model.sv]
`timescale 1ns/10ps
// Downstream capture logic: latches both ports on the complement strobe.
module capture_model
  import pixdemux_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       strobe_n_in,
  input  wire logic       oe_b_in,
  input  wire chan_data_t port_a_in,
  input  wire chan_data_t port_b_in,
  output chan_data_t      cap_a_out,
  output chan_data_t      cap_b_out,
  output chan_data_t      wire_b_out
);
  logic       last_n_reg;  // Previous complement strobe level.
  chan_data_t hold_b_reg;  // Last value that port B drove.
  // A floated port B shows the inverse of its last level, never a stale copy.
  assign wire_b_out = oe_b_in ? port_b_in : ~hold_b_reg;
  // The complement rises together with a new pair; taking the pair one clock
  // later means the data has settled when it is taken.
  always_ff @(posedge clk_in)
  begin
    last_n_reg <= strobe_n_in;
    // Only a driven level is remembered, so a floated port shows one value.
    if (oe_b_in)
    begin
      hold_b_reg <= port_b_in;
    end
    if (strobe_n_in && !last_n_reg)
    begin
      cap_a_out <= port_a_in;
      cap_b_out <= wire_b_out;
    end
  end
endmodule : capture_model

// [verif/tb_pixel_output_dual_port_select.sv]
`timescale 1ns/10ps
module tb_pixel_output_dual_port_select
  import pixdemux_pkg::*;
;
  // Pins driven by the bench, all given a value at time zero.
  logic       clk = 1'h0, rstn = 1'h0, pix = 1'h0, lsi = 1'h0, pol = 1'h1;
  logic       dual = 1'h0, par = 1'h0, pwr_n = 1'h1, gin = 1'h0, scl = 1'h0, sda = 1'h0;
  logic [2:0] phase = 3'h0;
  logic [1:0] straps = 2'h0;
  chan_data_t samp = 24'h0;
  // Design outputs and partner captures.
  chan_data_t pa, pb, cap_a, cap_b;
  logic [7:0] addr;
  logic       oe_a, oe_b, stb, stb_n, lso, t_oe, scl_s, sda_oe, sda_s, sda_o;
  // Reference model state.
  chan_data_t ea, eb, pend;
  int         idx, la, ls, ll, bd, bs, bl, cyc, err_total, n_checks;
  bit         ps, estb, ek, pwr = 1, cap_ok;

  always #2.5 clk = ~clk;

  pixel_output_dual_port_select DUT (
    .SYS_CLK_IN(clk), .RESETN_IN(rstn), .PIX_CLK_IN(pix), .SAMPLE_IN(samp),
    .LINE_SYNC_IN(lsi), .LINE_SYNC_POL_IN(pol), .DUAL_PORT_SELECT_IN(dual),
    .PARALLEL_OUTPUT_SELECT_IN(par), .SAMPLE_PHASE_IN(phase),
    .LOW_POWER_REQUEST_N_IN(pwr_n), .GREEN_SYNC_SLICE_IN(gin),
    .BUS_ADDRESS_LOW_PINS_IN(straps), .SERIAL_CLK_IN(scl), .SERIAL_DATA_IN(sda),
    .SERIAL_DATA_OUT(sda_o), .SERIAL_DATA_OE_OUT(sda_oe), .SERIAL_CLK_SYNC_OUT(scl_s),
    .SERIAL_DATA_SYNC_OUT(sda_s), .BUS_ADDRESS_OUT(addr), .PORT_A_OUT(pa),
    .PORT_A_OE_OUT(oe_a), .PORT_B_OUT(pb), .PORT_B_OE_OUT(oe_b),
    .OUTPUT_DATA_STROBE_OUT(stb), .OUTPUT_DATA_STROBE_N_OUT(stb_n),
    .LINE_SYNC_OUT(lso), .TIMING_OE_OUT(t_oe), .GREEN_SYNC_SLICE_OUT()
  );
  capture_model PEER (.clk_in(clk), .strobe_n_in(stb_n), .oe_b_in(oe_b), .port_a_in(pa),
    .port_b_in(pb), .cap_a_out(cap_a), .cap_b_out(cap_b), .wire_b_out());

  task finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Inputs always move one nanosecond after the rising edge.
  task tick();
    @(posedge clk);
    #1;
  endtask : tick

  // Settings change only while the pixel clock idles, so no word is split.
  task set_mode(input logic d, input logic p, input logic l);
    dual = d;
    par = p;
    pol = l;
    repeat (20) tick();
  endtask : set_mode

  task do_reset(input logic [1:0] a);
    rstn = 1'h0;
    straps = a;
    repeat (10) tick();
    rstn = 1'h1;
    ea = 24'h0;
    eb = 24'h0;
    idx = 0;
    ps = 0;
    estb = 0;
    ek = 1;
    repeat (4) tick();
    chk("addr", addr, 8'h98 | {5'h00, a, 1'h0});
    chk("port_a", pa, ea);
  endtask : do_reset

  // One 160 ns pixel: the model predicts, then the ports are checked.
  task px(input chan_data_t d, input bit s);
    if (pwr)
    begin
      if (s && !ps)
        idx = 0;
      ps = s;
      ek = ek && dual;
      if (!dual)
        ea = d;
      else if (idx % 2 == 0 && par)
        pend = d;
      else if (par)
      begin
        ea = pend;
        eb = d;
      end
      else if (idx % 2 == 0)
        ea = d;
      else
        eb = d;
      estb = estb ^ dual;
      idx++;
    end
    samp = d;
    lsi = s ~^ pol;
    scl = 1'($urandom);
    sda = 1'($urandom);
    tick();
    pix = 1'h1;
    la = -1;
    ls = -1;
    ll = -1;
    for (int i = 0; i < 31; i++)
    begin
      tick();
      gin = 1'($urandom);
      pix = pix && i != 15;
      if (la < 0 && pa === d)
        la = i;
      if (ls < 0 && stb === 1'h1)
        ls = i;
      if (ll < 0 && lso === s)
        ll = i;
    end
    chk("port_a", pa, ea);
    chk("oe_a", oe_a, pwr);
    chk("oe_b", oe_b, pwr && dual);
    chk("scl_sync", scl_s, scl);
    chk("sda_sync", sda_s, sda);
    chk("sda_out", sda_o, 1'h0);
    chk("sda_oe", sda_oe, 1'h0);
    if (pwr && dual)
      chk("port_b", pb, eb);
    if (pwr)
      chk("line_sync", lso, s);
    if (pwr && ek)
      chk("strobe", stb, estb);
    // Each captured port is compared on its own, so no bit is cut off.
    if (cap_ok && idx % 2 == 0)
    begin
      chk("cap_a", cap_a, ea);
      chk("cap_b", cap_b, eb);
    end
  endtask : px

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      err_total++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'hBE8F));
    do_reset(2'($urandom));
    set_mode(1'h1, 1'h1, 1'h1);
    cap_ok = 1;
    for (int n = 0; n < 12; n++)
      px(24'($urandom), n % 6 == 0);
    cap_ok = 0;
    for (int n = 0; n < 7; n++)
      px(24'($urandom), n == 0 || n == 3);
    set_mode(1'h1, 1'h0, 1'h0);
    for (int n = 0; n < 9; n++)
      px(24'($urandom), n == 0 || n == 5);
    set_mode(1'h0, 1'h0, 1'h1);
    for (int p = 0; p < 8; p++)
    begin
      phase = 3'(p);
      repeat (4) tick();
      px(24'($urandom), !p[0]);
      if (p == 0)
      begin
        bd = la;
        bs = ls;
        bl = ll - la;
      end
      chk("lat_data", la - bd, p);
      chk("lat_strobe", ls - bs, p);
      chk("lat_sync", ll - la, bl);
    end
    pwr_n = 1'h0;
    pwr = 0;
    repeat (8) tick();
    px(24'($urandom), 1);
    chk("timing_oe", t_oe, 1'h0);
    pwr_n = 1'h1;
    pwr = 1;
    estb = 0;
    ek = 1;
    set_mode(1'h1, 1'h0, 1'h1);
    for (int n = 0; n < 4; n++)
      px(24'($urandom), n == 0);
    for (int k = 0; k < 4; k++)
      do_reset(2'(k));
    finish_test();
  end
endmodule : tb_pixel_output_dual_port_select
